// ===== hw/mft_map.svh
// Register offsets, field positions and reset values of the timer controls
`ifndef MFT_MAP_SVH
`define MFT_MAP_SVH

`define MFT_A_ADC      8'h00
`define MFT_A_SKIP     8'h02
`define MFT_A_SYNC     8'h04
`define MFT_A_OE       8'h06
`define MFT_A_OCR1     8'h08
`define MFT_A_MODE     8'h0A
`define MFT_A_PHASE    8'h0C
`define MFT_A_ST_LO    8'h10
`define MFT_A_ST_HI    8'h12
`define MFT_A_EN_LO    8'h14
`define MFT_A_EN_HI    8'h16
`define MFT_A_CNT0     8'h20
`define MFT_A_CNT1     8'h22
`define MFT_A_CNT2     8'h24
`define MFT_A_CBUF     8'h26
`define MFT_A_CYC      8'h28
`define MFT_A_SKSTATE  8'h2A

`define MFT_NSRC       28
`define MFT_SRC_CH0_A  0
`define MFT_SRC_CH0_V  6
`define MFT_SRC_CH1_A  7
`define MFT_SRC_CH1_V  9
`define MFT_SRC_CH1_U  10
`define MFT_SRC_CH2_A  11
`define MFT_SRC_CH2_V  13
`define MFT_SRC_CH2_U  14
`define MFT_SRC_CH3_A  15
`define MFT_SRC_CH4_A  20
`define MFT_SRC_CH4_V  24

`define MFT_ADC_B_OVF  0
`define MFT_ADC_B_MAT  1
`define MFT_ADC_A_OVF  2
`define MFT_ADC_A_MAT  3
`define MFT_ADC_SEL_LO 6
`define MFT_ADC_SEL_HI 7
`define MFT_ADC_MASK   16'h00CF

`define MFT_SKP_EN_O   3
`define MFT_SKP_EN_M   7
`define MFT_OCR_PERIOD_TOGGLE_ENABLE   6
`define MFT_OCR_LOCK   3
`define MFT_OCR_POS_PHASE_LEVEL   0
`define MFT_OCR1_RST   8'h00
`define MFT_CLR_OWN    3'h1
`define MFT_CLR_SYNC   3'h3

`endif

// ===== hw/mft_pkg.sv
// Types shared by the timer control files
package mft_pkg;

  typedef enum logic [1:0] {
    MFT_NORMAL = 2'h0,
    MFT_PWM1   = 2'h1,
    MFT_RSYNC  = 2'h2,
    MFT_COMP   = 2'h3
  } mft_mode_type;

  typedef enum logic [1:0] {
    MFT_PH_FOUR  = 2'h0,
    MFT_PH_A     = 2'h1,
    MFT_PH_B     = 2'h2,
    MFT_PH_ARISE = 2'h3
  } mft_phase_type;

endpackage : mft_pkg

// ===== hw/mft_chan_cnt.sv
// One 16-bit channel counter with tick and phase counting
`timescale 1ns/1ps
module mft_chan_cnt
  import mft_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        tick_i,
  input  wire logic        phase_en_i,
  input  wire logic [1:0]  phase_mode_i,
  input  wire logic        phase_a_i,
  input  wire logic        phase_b_i,
  input  wire logic        load_i,
  input  wire logic [15:0] load_val_i,
  input  wire logic        clear_i,
  output logic      [15:0] count_o,
  output logic             ovf_o,
  output logic             udf_o
);

  logic        a_r, a_nxt, b_r, b_nxt;
  logic [15:0] cnt_nxt;
  logic        ovf_nxt, udf_nxt, up, dn;
  logic        ra, fa, rb, fb;

  always_comb
  begin
    ra = phase_a_i & ~a_r;
    fa = ~phase_a_i & a_r;
    rb = phase_b_i & ~b_r;
    fb = ~phase_b_i & b_r;
    a_nxt = phase_a_i;
    b_nxt = phase_b_i;
    up = tick_i;
    dn = 1'b0;
    if (phase_en_i)
    begin
      case (mft_phase_type'(phase_mode_i))
        MFT_PH_FOUR:
        begin
          up = (phase_a_i & rb) | (~phase_a_i & fb) | (~phase_b_i & ra) | (phase_b_i & fa);
          dn = (phase_a_i & fb) | (~phase_a_i & rb) | (phase_b_i & ra) | (~phase_b_i & fa);
        end
        MFT_PH_A:
        begin
          up = (~phase_b_i & ra) | (phase_b_i & fa);
          dn = (phase_b_i & ra) | (~phase_b_i & fa);
        end
        MFT_PH_B:
        begin
          up = (phase_a_i & rb) | (~phase_a_i & fb);
          dn = (phase_a_i & fb) | (~phase_a_i & rb);
        end
        MFT_PH_ARISE:
        begin
          up = ~phase_b_i & ra;
          dn = phase_b_i & ra;
        end
        default:
        begin
          up = 1'b0;
          dn = 1'b0;
        end
      endcase
    end
    cnt_nxt = count_o;
    ovf_nxt = 1'b0;
    udf_nxt = 1'b0;
    if (load_i)
      cnt_nxt = load_val_i;
    else if (clear_i)
      cnt_nxt = 16'h0000;
    else if (up)
    begin
      cnt_nxt = count_o + 16'h0001;
      ovf_nxt = (count_o == 16'hFFFF);
    end
    else if (dn)
    begin
      cnt_nxt = count_o - 16'h0001;
      udf_nxt = (count_o == 16'h0000);
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      a_r     <= 1'b0;
      b_r     <= 1'b0;
      count_o <= 16'h0000;
      ovf_o   <= 1'b0;
      udf_o   <= 1'b0;
    end
    else
    begin
      a_r     <= a_nxt;
      b_r     <= b_nxt;
      count_o <= cnt_nxt;
      ovf_o   <= ovf_nxt;
      udf_o   <= udf_nxt;
    end
  end

endmodule : mft_chan_cnt

// ===== hw/mft_ctrl.sv
// Timer control block: interrupt flags, skip-linked A/D starts, sync, outputs
// Function
// - Channel 0 has seven interrupt sources: A-D, E, F and overflow.
// - Channels 1 and 2 have four sources: A, B, overflow, underflow.
// - Channels 3, 4 have five sources each; channel 5 has U, V, W.
// - B start request link bit 0 passes request; 1 ties it to skipping.
// - Linked request with skipping disabled issues no A/D start.
// - Two-bit field picks cycle copy: never, crest, trough, both.
// - Crest copy point depends on mode: crest, 3A match or 4A match.
// - Sync bit 0 keeps channel counter independent; 1 joins sync group.
// - Writing a synced counter presets all synced counters; a sync clear clears synced counters whose clear select is sync.
// - Channel 3 B master enable 0 drives inactive level, 1 the waveform.
// - Outside PWM sync modes a disabled pin outputs low.
// - Output control one is 8 bits, reset zero; bit 6 enables toggle.
// - Lock bit 3 sets once after reset and then ignores writes of 0.
// - Bits 7, 5 and 4 of output control one read zero.
// - Phase counting counts up or down with four condition variants.
// - Phase mode one counts on edges of input A only, direction by B level.
`timescale 1ns/1ps
`include "mft_map.svh"
module mft_ctrl
  import mft_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic [7:0]  addr_i,
  input  wire logic [15:0] wdata_i,
  input  wire logic        we_i,
  input  wire logic        re_i,
  output logic      [15:0] rdata_o,
  input  wire logic [27:0] evt_i,
  input  wire logic [2:0]  tick_i,
  input  wire logic [1:0]  phase_a_i,
  input  wire logic [1:0]  phase_b_i,
  input  wire logic        crest_i,
  input  wire logic        trough_i,
  input  wire logic        wave_ch3_b_i,
  input  wire logic        adc_start_req_a_i,
  input  wire logic        adc_start_req_b_i,
  output logic      [27:0] irq_o,
  output logic             adc_req_a_o,
  output logic             adc_req_b_o,
  output logic             timer_pin_ch3_b_o,
  output logic             toggle_o
);

  logic [15:0] adc_r, adc_nxt, cbuf_r, cbuf_nxt, cyc_r, cyc_nxt, rd_nxt;
  logic [7:0]  skp_r, skp_nxt, ocr_r, ocr_nxt;
  logic [2:0]  syn_r, syn_nxt, skm_r, skm_nxt, sko_r, sko_nxt;
  logic [10:0] mode_r, mode_nxt;
  logic [5:0]  ph_r, ph_nxt;
  logic [27:0] en_r, en_nxt, flag_r, src;
  logic        oe_r, oe_nxt, pin_nxt, tog_nxt, rqa_nxt, rqb_nxt;
  logic [15:0] cnt [3];
  logic [2:0]  ovf, udf, own_clr, clr_src, load, clear;
  logic        sync_load, sync_clear, comp, rsync, crest_evt, xfer;
  logic        ok_m, ok_o, cm_on, co_on;
  mft_mode_type md;

  assign md    = mft_mode_type'(mode_r[1:0]);
  assign comp  = (md == MFT_COMP);
  assign rsync = (md == MFT_RSYNC);

  // Interrupt sources, internal overflow and underflow merged in
  always_comb
  begin
    src = evt_i;
    src[`MFT_SRC_CH0_V] = evt_i[`MFT_SRC_CH0_V] | ovf[0];
    src[`MFT_SRC_CH1_V] = evt_i[`MFT_SRC_CH1_V] | ovf[1];
    src[`MFT_SRC_CH1_U] = evt_i[`MFT_SRC_CH1_U] | udf[1];
    src[`MFT_SRC_CH2_V] = evt_i[`MFT_SRC_CH2_V] | ovf[2];
    src[`MFT_SRC_CH2_U] = evt_i[`MFT_SRC_CH2_U] | udf[2];
  end

  // Sticky flags, write one to clear, set wins
  genvar gi;
  generate
    for (gi = 0; gi < `MFT_NSRC; gi++)
    begin : g_flag
      logic clr, flag_nxt;
      if (gi < 16)
      begin : g_lo
        assign clr = we_i && (addr_i == `MFT_A_ST_LO) && wdata_i[gi];
      end
      else
      begin : g_hi
        assign clr = we_i && (addr_i == `MFT_A_ST_HI) && wdata_i[gi-16];
      end
      assign flag_nxt = src[gi] | (flag_r[gi] & ~clr);
      always_ff @(posedge clk_i or negedge rst_n_i)
      begin
        if (!rst_n_i)
          flag_r[gi] <= 1'b0;
        else
          flag_r[gi] <= flag_nxt;
      end
      assign irq_o[gi] = flag_r[gi] & en_r[gi];
    end
  endgenerate

  // Channel 0 to 2 counters with synchronous preset and clear
  assign own_clr   = {evt_i[`MFT_SRC_CH2_A], evt_i[`MFT_SRC_CH1_A], evt_i[`MFT_SRC_CH0_A]};
  assign sync_load = |(syn_r & {we_i && addr_i == `MFT_A_CNT2,
                                we_i && addr_i == `MFT_A_CNT1,
                                we_i && addr_i == `MFT_A_CNT0});
  assign sync_clear = |(syn_r & clr_src);

  generate
    for (gi = 0; gi < 3; gi++)
    begin : g_cnt
      logic [2:0] sel;
      logic       own_wr, ph_en;
      logic [1:0] ph_md;
      assign sel    = mode_r[3*gi+4 -: 3];
      assign own_wr = we_i && (addr_i == (`MFT_A_CNT0 + 8'(2*gi)));
      assign clr_src[gi] = own_clr[gi] && (sel == `MFT_CLR_OWN);
      assign load[gi]  = own_wr | (syn_r[gi] & sync_load);
      assign clear[gi] = clr_src[gi] |
                         (syn_r[gi] && (sel == `MFT_CLR_SYNC) && sync_clear);
      if (gi == 0)
      begin : g_noph
        assign ph_en = 1'b0;
        assign ph_md = 2'h0;
      end
      else
      begin : g_ph
        assign ph_en = ph_r[3*gi-3];
        assign ph_md = ph_r[3*gi-1 -: 2];
      end
      mft_chan_cnt u_cnt (
        .clk_i        (clk_i),
        .rst_n_i      (rst_n_i),
        .tick_i       (tick_i[gi]),
        .phase_en_i   (ph_en),
        .phase_mode_i (ph_md),
        .phase_a_i    (phase_a_i[(gi == 0) ? 0 : gi-1]),
        .phase_b_i    (phase_b_i[(gi == 0) ? 0 : gi-1]),
        .load_i       (load[gi]),
        .load_val_i   (wdata_i),
        .clear_i      (clear[gi]),
        .count_o      (cnt[gi]),
        .ovf_o        (ovf[gi]),
        .udf_o        (udf[gi])
      );
    end
  endgenerate

  // Cycle copy point
  always_comb
  begin
    if (comp)
      crest_evt = crest_i;
    else if (rsync)
      crest_evt = evt_i[`MFT_SRC_CH3_A];
    else
      crest_evt = evt_i[`MFT_SRC_CH4_A];
    case (adc_r[`MFT_ADC_SEL_HI:`MFT_ADC_SEL_LO])
      2'h1:    xfer = crest_evt;
      2'h2:    xfer = comp & trough_i;
      2'h3:    xfer = comp & (crest_i | trough_i);
      default: xfer = 1'b0;
    endcase
  end

  // Skip windows for linked A/D starts
  assign cm_on = skp_r[`MFT_SKP_EN_M] && (skp_r[6:4] != 3'h0);
  assign co_on = skp_r[`MFT_SKP_EN_O] && (skp_r[2:0] != 3'h0);
  assign ok_m  = cm_on && (skm_r == 3'h0);
  assign ok_o  = co_on && (sko_r == 3'h0);

  always_comb
  begin
    adc_nxt  = adc_r;
    skp_nxt  = skp_r;
    syn_nxt  = syn_r;
    oe_nxt   = oe_r;
    ocr_nxt  = ocr_r;
    mode_nxt = mode_r;
    ph_nxt   = ph_r;
    en_nxt   = en_r;
    cbuf_nxt = cbuf_r;
    cyc_nxt  = cyc_r;
    rd_nxt   = 16'h0000;
    if (we_i)
    begin
      case (addr_i)
        `MFT_A_ADC:   adc_nxt  = wdata_i & `MFT_ADC_MASK;
        `MFT_A_SKIP:  skp_nxt  = wdata_i[7:0];
        `MFT_A_SYNC:  syn_nxt  = wdata_i[2:0];
        `MFT_A_OE:    oe_nxt   = wdata_i[0];
        `MFT_A_OCR1:  ocr_nxt  = {1'b0, wdata_i[6], 2'b00,
                                  ocr_r[3] | wdata_i[3], wdata_i[2:0]};
        `MFT_A_MODE:  mode_nxt = wdata_i[10:0];
        `MFT_A_PHASE: ph_nxt   = wdata_i[5:0];
        `MFT_A_EN_LO: en_nxt[15:0]  = wdata_i;
        `MFT_A_EN_HI: en_nxt[27:16] = wdata_i[11:0];
        `MFT_A_CBUF:  cbuf_nxt = wdata_i;
        `MFT_A_CYC:   cyc_nxt  = wdata_i;
        default:      ;
      endcase
    end
    if (xfer)
      cyc_nxt = cbuf_r;
    skm_nxt = skm_r;
    if (!cm_on)
      skm_nxt = 3'h0;
    else if (evt_i[`MFT_SRC_CH3_A])
      skm_nxt = (skm_r + 3'h1 == skp_r[6:4]) ? 3'h0 : skm_r + 3'h1;
    sko_nxt = sko_r;
    if (!co_on)
      sko_nxt = 3'h0;
    else if (evt_i[`MFT_SRC_CH4_V])
      sko_nxt = (sko_r + 3'h1 == skp_r[2:0]) ? 3'h0 : sko_r + 3'h1;
    rqb_nxt = adc_start_req_b_i &&
              ((!adc_r[`MFT_ADC_B_OVF] && !adc_r[`MFT_ADC_B_MAT]) ||
               (adc_r[`MFT_ADC_B_OVF] && ok_o) ||
               (adc_r[`MFT_ADC_B_MAT] && ok_m));
    rqa_nxt = adc_start_req_a_i &&
              ((!adc_r[`MFT_ADC_A_OVF] && !adc_r[`MFT_ADC_A_MAT]) ||
               (adc_r[`MFT_ADC_A_OVF] && ok_o) ||
               (adc_r[`MFT_ADC_A_MAT] && ok_m));
    if (oe_r)
      pin_nxt = wave_ch3_b_i;
    else if (comp || rsync)
      pin_nxt = ~ocr_r[`MFT_OCR_POS_PHASE_LEVEL];
    else
      pin_nxt = 1'b0;
    tog_nxt = toggle_o ^ (ocr_r[`MFT_OCR_PERIOD_TOGGLE_ENABLE] && (comp || rsync) && crest_i);
    if (re_i)
    begin
      case (addr_i)
        `MFT_A_ADC:     rd_nxt = adc_r;
        `MFT_A_SKIP:    rd_nxt = {8'h00, skp_r};
        `MFT_A_SYNC:    rd_nxt = {13'h0000, syn_r};
        `MFT_A_OE:      rd_nxt = {15'h0000, oe_r};
        `MFT_A_OCR1:    rd_nxt = {8'h00, ocr_r};
        `MFT_A_MODE:    rd_nxt = {5'h00, mode_r};
        `MFT_A_PHASE:   rd_nxt = {10'h000, ph_r};
        `MFT_A_ST_LO:   rd_nxt = flag_r[15:0];
        `MFT_A_ST_HI:   rd_nxt = {4'h0, flag_r[27:16]};
        `MFT_A_EN_LO:   rd_nxt = en_r[15:0];
        `MFT_A_EN_HI:   rd_nxt = {4'h0, en_r[27:16]};
        `MFT_A_CNT0:    rd_nxt = cnt[0];
        `MFT_A_CNT1:    rd_nxt = cnt[1];
        `MFT_A_CNT2:    rd_nxt = cnt[2];
        `MFT_A_CBUF:    rd_nxt = cbuf_r;
        `MFT_A_CYC:     rd_nxt = cyc_r;
        `MFT_A_SKSTATE: rd_nxt = {9'h000, skm_r, 1'b0, sko_r};
        default:        rd_nxt = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      adc_r  <= 16'h0000;
      skp_r  <= 8'h00;
      syn_r  <= 3'h0;
      oe_r   <= 1'b0;
      ocr_r  <= `MFT_OCR1_RST;
      mode_r <= 11'h000;
      ph_r   <= 6'h00;
      en_r   <= 28'h0000000;
      cbuf_r <= 16'h0000;
      cyc_r  <= 16'h0000;
      skm_r  <= 3'h0;
      sko_r  <= 3'h0;
      rdata_o           <= 16'h0000;
      adc_req_a_o       <= 1'b0;
      adc_req_b_o       <= 1'b0;
      timer_pin_ch3_b_o <= 1'b0;
      toggle_o          <= 1'b0;
    end
    else
    begin
      adc_r  <= adc_nxt;
      skp_r  <= skp_nxt;
      syn_r  <= syn_nxt;
      oe_r   <= oe_nxt;
      ocr_r  <= ocr_nxt;
      mode_r <= mode_nxt;
      ph_r   <= ph_nxt;
      en_r   <= en_nxt;
      cbuf_r <= cbuf_nxt;
      cyc_r  <= cyc_nxt;
      skm_r  <= skm_nxt;
      sko_r  <= sko_nxt;
      rdata_o           <= rd_nxt;
      adc_req_a_o       <= rqa_nxt;
      adc_req_b_o       <= rqb_nxt;
      timer_pin_ch3_b_o <= pin_nxt;
      toggle_o          <= tog_nxt;
    end
  end

  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  property p_irq_on_event;
    evt_i[0] && en_r[0] && !we_i |=> irq_o[0] [*2];
  endproperty
  a_irq_on_event: assert property (p_irq_on_event) else $error("irq not raised");

  property p_lock_stays;
    ocr_r[`MFT_OCR_LOCK] |=> ocr_r[`MFT_OCR_LOCK];
  endproperty
  a_lock_stays: assert property (p_lock_stays) else $error("lock bit cleared");

  property p_ocr_reserved;
    re_i && addr_i == `MFT_A_OCR1 |=> (rdata_o[15:4] & 12'hFFB) == 12'h000;
  endproperty
  a_ocr_reserved: assert property (p_ocr_reserved) else $error("reserved bits set");

  property p_pin_low;
    !oe_r && !comp && !rsync |=> !timer_pin_ch3_b_o;
  endproperty
  a_pin_low: assert property (p_pin_low) else $error("disabled pin not low");

  property p_pin_wave;
    oe_r |=> timer_pin_ch3_b_o == $past(wave_ch3_b_i);
  endproperty
  a_pin_wave: assert property (p_pin_wave) else $error("pin lost waveform");

  sequence s_crest_sel;
    comp && adc_r[7:6] == 2'h1 && crest_i;
  endsequence
  property p_crest_copy;
    s_crest_sel |=> cyc_r == $past(cbuf_r);
  endproperty
  a_crest_copy: assert property (p_crest_copy) else $error("no crest copy");

  property p_no_copy;
    adc_r[7:6] == 2'h0 && !(we_i && addr_i == `MFT_A_CYC) |=> $stable(cyc_r);
  endproperty
  a_no_copy: assert property (p_no_copy) else $error("cycle changed");

  property p_link_dead;
    adc_r[1:0] == 2'h1 && !skp_r[`MFT_SKP_EN_O] |=> !adc_req_b_o;
  endproperty
  a_link_dead: assert property (p_link_dead) else $error("start issued");

  property p_unlinked;
    adc_r[1:0] == 2'h0 && adc_start_req_b_i |=> adc_req_b_o;
  endproperty
  a_unlinked: assert property (p_unlinked) else $error("start dropped");

  property p_sync_preset;
    we_i && addr_i == `MFT_A_CNT0 && syn_r[1:0] == 2'h3 |=> cnt[1] == $past(wdata_i);
  endproperty
  a_sync_preset: assert property (p_sync_preset) else $error("no sync preset");

  property p_toggle;
    ocr_r[`MFT_OCR_PERIOD_TOGGLE_ENABLE] && comp && crest_i |=> toggle_o != $past(toggle_o);
  endproperty
  a_toggle: assert property (p_toggle) else $error("no toggle");

endmodule : mft_ctrl

// ===== verification/mft_far_model.sv
// Far-side model: A/D converter start counter and power stage pin monitor
`timescale 1ns/1ps
module mft_far_model (
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       adc_req_a_i,
  input  wire logic       adc_req_b_i,
  input  wire logic       stage_pin_i,
  input  wire logic       stage_toggle_i,
  output logic      [7:0] starts_a_o,
  output logic      [7:0] starts_b_o,
  output logic            stage_level_o,
  output logic            stage_toggle_o
);
  // Converter starts once per request cycle; stage samples the pin each rising clock edge
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      starts_a_o     <= 8'h00;
      starts_b_o     <= 8'h00;
      stage_level_o  <= 1'b0;
      stage_toggle_o <= 1'b0;
    end
    else
    begin
      starts_a_o     <= starts_a_o + {7'h00, adc_req_a_i};
      starts_b_o     <= starts_b_o + {7'h00, adc_req_b_i};
      stage_level_o  <= stage_pin_i;
      stage_toggle_o <= stage_toggle_i;
    end
  end
endmodule : mft_far_model

// ===== verification/tb_top.sv
// Self-checking testbench for the timer control block
`timescale 1ns/1ps
`include "mft_map.svh"
module tb_top
  import mft_pkg::*;
;
  logic        clk_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic [7:0]  addr_i = 8'h00;
  logic [15:0] wdata_i = 16'h0000;
  logic        we_i = 1'b0;
  logic        re_i = 1'b0;
  logic [15:0] rdata_o;
  logic [27:0] evt_i = 28'h0000000;
  logic [2:0]  tick_i = 3'h0;
  logic [1:0]  phase_a_i = 2'h0;
  logic [1:0]  phase_b_i = 2'h0;
  logic        crest_i = 1'b0;
  logic        trough_i = 1'b0;
  logic        wave_ch3_b_i = 1'b0;
  logic        req_a_raw = 1'b0;
  logic        req_b_raw = 1'b0;
  logic [27:0] irq_o;
  logic        adc_req_a_o;
  logic        adc_req_b_o;
  logic        timer_pin_ch3_b_o;
  logic        toggle_o;
  logic [7:0]  starts_a;
  logic [7:0]  starts_b;
  logic        stage_level;
  logic        stage_toggle;
  logic [15:0] rd_val;
  logic [15:0] cyc_exp;
  logic        tog_exp;
  int          fail_count = 0;
  int          compares = 0;
  int          cycles = 0;

  always #50 clk_i = ~clk_i;

  mft_ctrl u_mft_ctrl (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i), .we_i(we_i),
    .re_i(re_i), .rdata_o(rdata_o), .evt_i(evt_i), .tick_i(tick_i),
    .phase_a_i(phase_a_i), .phase_b_i(phase_b_i), .crest_i(crest_i),
    .trough_i(trough_i), .wave_ch3_b_i(wave_ch3_b_i), .adc_start_req_a_i(req_a_raw),
    .adc_start_req_b_i(req_b_raw), .irq_o(irq_o), .adc_req_a_o(adc_req_a_o),
    .adc_req_b_o(adc_req_b_o), .timer_pin_ch3_b_o(timer_pin_ch3_b_o), .toggle_o(toggle_o)
  );

  mft_far_model u_mft_far_model (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .adc_req_a_i(adc_req_a_o),
    .adc_req_b_i(adc_req_b_o), .stage_pin_i(timer_pin_ch3_b_o),
    .stage_toggle_i(toggle_o), .starts_a_o(starts_a), .starts_b_o(starts_b),
    .stage_level_o(stage_level), .stage_toggle_o(stage_toggle)
  );

  task automatic stop_test();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : stop_test

  task automatic chk_reg(input string what, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp)
    begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_reg

  task automatic chk_irq(input logic [27:0] exp);
    compares++;
    if (irq_o !== exp)
    begin
      fail_count++;
      $display("unexpected irq_o expected %h seen %h", exp, irq_o);
    end
  endtask : chk_irq

  task automatic chk_bit(input string what, input logic exp, input logic got);
    compares++;
    if (got !== exp)
    begin
      fail_count++;
      $display("unexpected %s expected %b seen %b", what, exp, got);
    end
  endtask : chk_bit

  // Always a full 16-bit transfer
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_i);
    we_i    <= 1'b1;
    addr_i  <= a;
    wdata_i <= d;
    @(posedge clk_i);
    we_i    <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk_i);
    re_i   <= 1'b1;
    addr_i <= a;
    @(posedge clk_i);
    re_i   <= 1'b0;
    #1;
    d = rdata_o;
  endtask : rd

  task automatic evt_pulse(input logic [27:0] v);
    @(posedge clk_i);
    evt_i <= v;
    @(posedge clk_i);
    evt_i <= 28'h0000000;
    #1;
  endtask : evt_pulse

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : wait_cyc

  // Fires one of the four copy points: 0 crest, 1 trough, 2 ch3 A match, 3 ch4 A match
  task automatic copy_event(input int k);
    @(posedge clk_i);
    crest_i  <= (k == 0);
    trough_i <= (k == 1);
    evt_i    <= (k == 2) ? 28'h0008000 : ((k == 3) ? 28'h0100000 : 28'h0000000);
    @(posedge clk_i);
    crest_i  <= 1'b0;
    trough_i <= 1'b0;
    evt_i    <= 28'h0000000;
  endtask : copy_event

  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      fail_count++;
      stop_test();
    end
  end

  logic [1:0] cp_mode [5] = '{2'h0, 2'h2, 2'h3, 2'h3, 2'h3};
  logic [1:0] cp_sel  [5] = '{2'h1, 2'h1, 2'h2, 2'h0, 2'h1};
  int         cp_evt  [5] = '{3, 2, 1, 0, 0};

  initial
  begin
    repeat (2) @(posedge clk_i);
    rst_n_i <= 1'b1;
    // Reset value and read timing
    rd(`MFT_A_OCR1, rd_val);
    chk_reg("ocr1 reset", 16'h0000, rd_val);
    wait_cyc(1);
    chk_reg("rdata after read", 16'h0000, rdata_o);
    rd(8'hFE, rd_val);
    chk_reg("unmapped read", 16'h0000, rd_val);
    // Reserved bits written zero and read zero, lock bit survives a write of zero
    wr(`MFT_A_OCR1, 16'h004F);
    rd(`MFT_A_OCR1, rd_val);
    chk_reg("ocr1 all ones", 16'h004F, rd_val);
    wr(`MFT_A_OCR1, 16'h0000);
    rd(`MFT_A_OCR1, rd_val);
    chk_reg("ocr1 lock kept", 16'h0008, rd_val);
    // Flag without enable gives no request
    evt_pulse(28'h0000040);
    chk_irq(28'h0000000);
    rd(`MFT_A_ST_LO, rd_val);
    chk_reg("status lo", 16'h0040, rd_val);
    wr(`MFT_A_ST_LO, 16'hFFFF);
    wr(`MFT_A_EN_LO, 16'hFFFF);
    wr(`MFT_A_EN_HI, 16'h0FFF);
    // Every source of every channel raises only its own request
    for (int i = 0; i < 28; i++)
    begin
      evt_pulse(28'h0000001 << i);
      chk_irq(28'h0000001 << i);
      wr(`MFT_A_ST_LO, 16'hFFFF);
      wr(`MFT_A_ST_HI, 16'h0FFF);
    end
    wait_cyc(1);
    chk_irq(28'h0000000);
    // Channels 0 and 1 synced, channel 2 independent
    wr(`MFT_A_SYNC, 16'h0003);
    wr(`MFT_A_CNT0, 16'h1234);
    rd(`MFT_A_CNT1, rd_val);
    chk_reg("synced count", 16'h1234, rd_val);
    rd(`MFT_A_CNT2, rd_val);
    chk_reg("independent count", 16'h0000, rd_val);
    // Cycle buffer copy points
    for (int i = 0; i < 5; i++)
    begin
      wr(`MFT_A_MODE, {14'h0000, cp_mode[i]});
      wr(`MFT_A_ADC, {8'h00, cp_sel[i], 6'h00});
      wr(`MFT_A_CBUF, 16'hA100 + 16'(i));
      copy_event(cp_evt[i]);
      if (cp_sel[i] != 2'h0)
        cyc_exp = 16'hA100 + 16'(i);
      rd(`MFT_A_CYC, rd_val);
      chk_reg("cycle register", cyc_exp, rd_val);
    end
    // Start requests: unlinked pass, linked B with skipping off is dropped
    wr(`MFT_A_ADC, 16'h0000);
    @(posedge clk_i);
    req_a_raw <= 1'b1;
    req_b_raw <= 1'b1;
    @(posedge clk_i);
    req_a_raw <= 1'b0;
    req_b_raw <= 1'b0;
    wait_cyc(3);
    chk_reg("starts b unlinked", 16'h0001, {8'h00, starts_b});
    chk_reg("starts a unlinked", 16'h0001, {8'h00, starts_a});
    wr(`MFT_A_MODE, 16'h0003);
    wr(`MFT_A_SKIP, 16'h0000);
    wr(`MFT_A_ADC, 16'h0001);
    @(posedge clk_i);
    req_b_raw <= 1'b1;
    @(posedge clk_i);
    req_b_raw <= 1'b0;
    wait_cyc(3);
    chk_reg("starts b linked", 16'h0001, {8'h00, starts_b});
    // Pin: disabled in normal mode is low, enabled follows wave, comp gives inactive
    wr(`MFT_A_MODE, 16'h0000);
    wave_ch3_b_i <= 1'b1;
    wr(`MFT_A_OE, 16'h0000);
    wait_cyc(2);
    chk_bit("pin disabled", 1'b0, stage_level);
    wr(`MFT_A_OE, 16'h0001);
    wait_cyc(2);
    chk_bit("pin enabled", 1'b1, stage_level);
    wr(`MFT_A_OE, 16'h0000);
    wr(`MFT_A_MODE, 16'h0003);
    wait_cyc(2);
    chk_bit("pin inactive", 1'b1, stage_level);
    // Toggle output in complementary mode, never toggled before
    wr(`MFT_A_OCR1, 16'h0040);
    wait_cyc(1);
    tog_exp = 1'b1;
    copy_event(0);
    wait_cyc(1);
    chk_bit("toggle", tog_exp, toggle_o);
    stop_test();
  end
endmodule : tb_top
